// ---- rtl/brmagu_agu.sv ----
`timescale 1ns/100ps
// How it works
// - modulo correction usable on any pointer register
// - wrap on crossing bound, not only equality
// - offset mode corrects access, leaves pointer alone
// - bit-reverse only for X-space writes
// - only the carry direction is reversed
// - needs select not 15, enable, pre/post-inc
// - 15-bit modifier, half the buffer size
// - word data assumed, modifier scaled to bytes
// - byte access or other mode gets normal address
// - add modifier with reversed carry, lsb clear
// - bit-reverse beats modulo on writes only
// - 16-entry buffer yields mirrored index sequence
module brmagu_agu
  import brmagu_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              req_valid,
  input  wire brmagu_req_t       req,
  input  wire logic              modulo_enable,
  input  wire logic [IDX_W-1:0]  modulo_ptr_select,
  input  wire logic [15:0]       modulo_start,
  input  wire logic [15:0]       modulo_end,
  input  wire logic              bitrev_enable,
  input  wire logic [IDX_W-1:0]  bitrev_pointer_select,
  input  wire logic [MOD_W-1:0]  bitrev_modifier,
  output logic                   res_valid,
  output brmagu_res_t            res
);

  logic        mode_inc;
  logic        mode_dec;
  logic        mode_pre;
  logic        go_up;
  logic        br_active;
  logic        mod_active;
  logic        wrap;
  logic [15:0] step;
  logic [15:0] upd;
  logic [15:0] mod_len;
  logic [15:0] corrected;
  logic [15:0] br_mod;
  logic [15:0] br_next;
  logic [15:0] nxt_addr;
  logic [15:0] nxt_wb_val;
  logic        nxt_wb_en;
  logic        res_valid_ff;
  brmagu_res_t res_ff;
  logic [15:0] chk_br_rsum;
  logic [15:0] chk_br_sum;

  // mode decode
  always_comb
  begin
    mode_inc = (req.mode == BRMAGU_MODE_POST_INC) ||
               (req.mode == BRMAGU_MODE_PRE_INC);
    mode_dec = (req.mode == BRMAGU_MODE_POST_DEC) ||
               (req.mode == BRMAGU_MODE_PRE_DEC);
    mode_pre = (req.mode == BRMAGU_MODE_PRE_INC) ||
               (req.mode == BRMAGU_MODE_PRE_DEC);
  end

  // bit-reverse qualification; the stack pointer can never take part
  always_comb
  begin
    br_active = req.x_space && req.is_write &&
                !req.is_byte &&
                bitrev_enable &&
                (bitrev_pointer_select != STACK_IDX) &&
                (req.ptr_idx == bitrev_pointer_select) &&
                mode_inc;
  end

  // modifier counts words, so shift once for byte addresses
  assign br_mod = {bitrev_modifier, 1'b0};

  brmagu_revadd u_revadd (
    .ptr      ({req.ptr_val[15:1], 1'b0}),
    .modifier (br_mod),
    .sum      (br_next)
  );

  // plain pointer update by mode
  always_comb
  begin
    step = req.is_byte ? STEP_BYTE : STEP_WORD;
    case (req.mode)
      BRMAGU_MODE_POST_INC, BRMAGU_MODE_PRE_INC: upd = req.ptr_val + step;
      BRMAGU_MODE_POST_DEC, BRMAGU_MODE_PRE_DEC: upd = req.ptr_val - step;
      BRMAGU_MODE_OFFSET:                        upd = req.ptr_val + req.offset;
      default:                                   upd = req.ptr_val;
    endcase
  end

  // modulo wrap: a magnitude compare so a step that jumps past a
  // bound is still pulled back; an equality test would miss it
  always_comb
  begin
    mod_active = modulo_enable &&
                 (req.ptr_idx == modulo_ptr_select) &&
                 !br_active;
    go_up   = mode_inc ||
              ((req.mode == BRMAGU_MODE_OFFSET) && !req.offset[15]);
    mod_len = modulo_end - modulo_start + STEP_BYTE;
    wrap    = 1'b0;
    if (mod_active && (mode_inc || mode_dec ||
                       (req.mode == BRMAGU_MODE_OFFSET)))
    begin
      if (go_up)
      begin
        wrap = (upd > modulo_end);
      end
      else
      begin
        wrap = (upd < modulo_start);
      end
    end
    if (!wrap)
    begin
      corrected = upd;
    end
    else if (go_up)
    begin
      corrected = upd - mod_len;
    end
    else
    begin
      corrected = upd + mod_len;
    end
  end

  // effective address and write-back selection
  always_comb
  begin
    nxt_wb_en = mode_inc || mode_dec;
    if (br_active)
    begin
      // mode offset ignored, lsb forced clear
      nxt_wb_val = {br_next[15:1], 1'b0};
      nxt_addr   = mode_pre ? {br_next[15:1], 1'b0} :
                              {req.ptr_val[15:1], 1'b0};
    end
    else
    begin
      nxt_wb_val = corrected;
      if (mode_pre || (req.mode == BRMAGU_MODE_OFFSET))
      begin
        nxt_addr = corrected;
      end
      else
      begin
        nxt_addr = req.ptr_val;
      end
    end
  end

  // result valid strobe
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      res_valid_ff <= 1'b0;
    end
    else
    begin
      res_valid_ff <= req_valid;
    end
  end

  // result word, cleared to a harmless idle value between requests
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      res_ff <= '0;
    end
    else if (req_valid)
    begin
      res_ff.addr    <= nxt_addr;
      res_ff.wb_en   <= nxt_wb_en;
      res_ff.wb_idx  <= req.ptr_idx;
      res_ff.wb_val  <= nxt_wb_val;
      res_ff.bitrev  <= br_active;
      res_ff.wrapped <= wrap;
    end
    else
    begin
      res_ff <= '0;
    end
  end

  assign res_valid = res_valid_ff;
  assign res       = res_ff;

  // checks
  AST_BR_LSB_CLEAR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    res_valid && res.bitrev |-> !res.addr[0] && !res.wb_val[0])
    else $error("bit-reversed address has lsb set");

  AST_OFFSET_NO_WB: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req.mode == BRMAGU_MODE_OFFSET |=> !res.wb_en)
    else $error("offset mode wrote the pointer back");

  AST_READ_NO_BR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && (!req.is_write || !req.x_space) |=> !res.bitrev)
    else $error("bit reverse used off the write path");

  AST_STACK_NO_BR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && bitrev_pointer_select == STACK_IDX |=> !res.bitrev)
    else $error("bit reverse applied to stack pointer");

  AST_BYTE_NORMAL: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req.is_byte |=> !res.bitrev)
    else $error("byte access took bit-reversed address");

  // independent reversed-carry sum for the step check; the carry that runs
  // off the bottom of the buffer lands in bit 0, which must read as clear
  always_comb
  begin
    chk_br_rsum = brmagu_rev16({req.ptr_val[15:1], 1'b0}) +
                  brmagu_rev16({bitrev_modifier, 1'b0});
    chk_br_sum  = brmagu_rev16(chk_br_rsum) & 16'hFFFE;
  end

  AST_BR_STEP: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && br_active |=> res.wb_en &&
      res.wb_val == $past(chk_br_sum))
    else $error("bit-reversed pointer step wrong");

  AST_BR_PRIO: assert property (@(posedge sys_clk) disable iff (!arst_n)
    res_valid && res.bitrev |-> !res.wrapped)
    else $error("modulo acted together with bit reverse");

  AST_WRAP_IN_RANGE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && wrap && !req.is_byte && (mode_inc || mode_dec) &&
    (modulo_end > modulo_start) &&
    (req.ptr_val >= modulo_start) && (req.ptr_val <= modulo_end) |=>
      res.wb_val >= $past(modulo_start) &&
      res.wb_val <= $past(modulo_end))
    else $error("wrapped pointer left the buffer");

  AST_PLAIN_POST_INC: assert property (@(posedge sys_clk) disable iff (!arst_n)
    req_valid && req.mode == BRMAGU_MODE_POST_INC && !br_active && !wrap |=>
      res.addr == $past(req.ptr_val) &&
      res.wb_val == $past(req.ptr_val) +
        ($past(req.is_byte) ? STEP_BYTE : STEP_WORD))
    else $error("plain post-increment wrong");

  COV_BR_WRITE: cover property (@(posedge sys_clk) disable iff (!arst_n)
    res_valid && res.bitrev);
  COV_MOD_WRAP: cover property (@(posedge sys_clk) disable iff (!arst_n)
    res_valid && res.wrapped && res.wb_en);
  COV_OFFSET_WRAP: cover property (@(posedge sys_clk) disable iff (!arst_n)
    res_valid && res.wrapped && !res.wb_en);
  COV_BR_BACK2BACK: cover property (@(posedge sys_clk) disable iff (!arst_n)
    res_valid && res.bitrev ##1 res_valid && res.bitrev);

endmodule : brmagu_agu

// ---- rtl/brmagu_pkg.sv ----
package brmagu_pkg;

  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned IDX_W       = 4;
  localparam int unsigned MOD_W       = 15;
  // pointer index reserved for the stack, never a bit-reversed pointer
  localparam logic [3:0]  STACK_IDX   = 4'hF;
  localparam logic [15:0] STEP_BYTE   = 16'h0001;
  localparam logic [15:0] STEP_WORD   = 16'h0002;
  localparam logic [15:0] ADDR_ZERO   = 16'h0000;

  typedef enum logic [2:0] {
    BRMAGU_MODE_IND,
    BRMAGU_MODE_POST_INC,
    BRMAGU_MODE_POST_DEC,
    BRMAGU_MODE_PRE_INC,
    BRMAGU_MODE_PRE_DEC,
    BRMAGU_MODE_OFFSET
  } brmagu_mode_t;

  typedef struct packed {
    logic [3:0]   ptr_idx;
    logic [15:0]  ptr_val;
    brmagu_mode_t mode;
    logic [15:0]  offset;
    logic         is_write;
    logic         is_byte;
    logic         x_space;
  } brmagu_req_t;

  typedef struct packed {
    logic [15:0]  addr;
    logic         wb_en;
    logic [3:0]   wb_idx;
    logic [15:0]  wb_val;
    logic         bitrev;
    logic         wrapped;
  } brmagu_res_t;

  // mirror the bit order of an address word
  function automatic logic [15:0] brmagu_rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : brmagu_rev16

endpackage : brmagu_pkg

// ---- rtl/brmagu_revadd.sv ----
`timescale 1ns/100ps
// adder whose carry runs from msb toward lsb
module brmagu_revadd
  import brmagu_pkg::*;
(
  input  wire logic [15:0] ptr,
  input  wire logic [15:0] modifier,
  output logic      [15:0] sum
);

  logic [15:0] rsum;

  // only the carry direction is reversed; ptr and result stay in normal order
  always_comb
  begin
    rsum = brmagu_rev16(ptr) + brmagu_rev16(modifier);
    sum  = brmagu_rev16(rsum);
  end

endmodule : brmagu_revadd

// ---- testbench/brmagu_mem_model.sv ----
`timescale 1ns/100ps
// memory side: counts every access the generator hands over
module brmagu_mem_model
  import brmagu_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   arst_n,
  input  wire logic   res_valid,
  output logic [15:0] access_count_ff
);
  // contents not modelled; the count proves no access is lost or doubled
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      access_count_ff <= 16'h0000;
    else if (res_valid)
      access_count_ff <= access_count_ff + 16'h0001;
  end
endmodule : brmagu_mem_model

// ---- testbench/brmagu_agu_test.sv ----
`timescale 1ns/100ps
module brmagu_agu_test
  import brmagu_pkg::*;
;
  typedef struct packed {
    logic me; logic [3:0] ms; logic [15:0] st; logic [15:0] en;
    logic be; logic [3:0] bs; logic [14:0] bm;
  } brmagu_cfg_t;
  logic             sys_clk, arst_n, req_valid, res_valid, pend_v;
  logic             modulo_enable, bitrev_enable;
  logic [3:0]       modulo_ptr_select, bitrev_pointer_select;
  logic [15:0]      modulo_start, modulo_end, seen_count, p;
  logic [14:0]      bitrev_modifier;
  logic [31:0]      w;
  brmagu_req_t      req, r;
  brmagu_res_t      res, pend;
  brmagu_cfg_t      c;
  int               err_count, checks_done, seed, n_req;

  brmagu_agu u_brmagu_agu (.sys_clk(sys_clk), .arst_n(arst_n),
    .req_valid(req_valid), .req(req), .modulo_enable(modulo_enable),
    .modulo_ptr_select(modulo_ptr_select), .modulo_start(modulo_start),
    .modulo_end(modulo_end), .bitrev_enable(bitrev_enable),
    .bitrev_pointer_select(bitrev_pointer_select),
    .bitrev_modifier(bitrev_modifier), .res_valid(res_valid), .res(res));
  brmagu_mem_model u_brmagu_mem_model (.sys_clk(sys_clk), .arst_n(arst_n),
    .res_valid(res_valid), .access_count_ff(seen_count));

  // free-running 200 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] flip(input logic [15:0] v);
    logic [15:0] o;
    for (int i = 0; i < 16; i++)
    begin
      o[i] = v[15 - i];
    end
    return o;
  endfunction : flip

  // expected result worked out from the addressing rules
  function automatic brmagu_res_t model(brmagu_req_t q, brmagu_cfg_t k);
    brmagu_res_t o;
    logic [15:0] s, u;
    logic br, inc, pre, up;
    o = '0;
    s = q.is_byte ? STEP_BYTE : STEP_WORD;
    inc = q.mode inside {BRMAGU_MODE_POST_INC, BRMAGU_MODE_PRE_INC};
    pre = q.mode inside {BRMAGU_MODE_PRE_INC, BRMAGU_MODE_PRE_DEC,
                         BRMAGU_MODE_OFFSET};
    up = inc | (q.mode == BRMAGU_MODE_OFFSET & !q.offset[15]);
    br = q.x_space & q.is_write & !q.is_byte & k.be & inc
       & k.bs != STACK_IDX & q.ptr_idx == k.bs;
    case (q.mode)
      BRMAGU_MODE_IND: u = q.ptr_val;
      BRMAGU_MODE_OFFSET: u = q.ptr_val + q.offset;
      default: u = inc ? q.ptr_val + s : q.ptr_val - s;
    endcase
    if (br)
      u = flip(flip(q.ptr_val) + flip({k.bm, 1'b0})) & 16'hFFFE;
    else if (k.me & q.ptr_idx == k.ms & q.mode != BRMAGU_MODE_IND)
    begin
      if (up & u > k.en)
      begin
        u = u - (k.en - k.st + 16'h0001);
        o.wrapped = 1'b1;
      end
      else if (!up & u < k.st)
      begin
        u = u + (k.en - k.st + 16'h0001);
        o.wrapped = 1'b1;
      end
    end
    o.addr = pre ? u : (br ? q.ptr_val & 16'hFFFE : q.ptr_val);
    o.wb_en = !(q.mode inside {BRMAGU_MODE_IND, BRMAGU_MODE_OFFSET});
    o.wb_idx = q.ptr_idx;
    o.wb_val = u;
    o.bitrev = br;
    return o;
  endfunction : model

  task check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // drive one cycle, then judge the answer to the previous cycle
  task issue(input brmagu_req_t q, input logic v, input brmagu_cfg_t k);
    @(posedge sys_clk);
    req_valid <= v;
    req <= q;
    {modulo_enable, modulo_ptr_select, modulo_start, modulo_end,
     bitrev_enable, bitrev_pointer_select, bitrev_modifier} <= k;
    #1;
    check(res_valid, pend_v);
    if (pend_v)
    begin
      check(res.addr, pend.addr);
      check(res.wrapped, pend.wrapped);
      check(res.wb_en, pend.wb_en);
      check(res.bitrev, pend.bitrev);
      if (pend.wb_en)
      begin
        check(res.wb_idx, pend.wb_idx);
        check(res.wb_val, pend.wb_val);
      end
    end
    else
      check(res.addr, ADDR_ZERO);
    pend_v = v;
    pend = model(q, k);
    n_req += v;
  endtask : issue

  task tally_and_finish();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #(5 * 4000);
    err_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial
  begin
    seed = 49292;
    {err_count, checks_done, n_req} = '0;
    {arst_n, req_valid, pend_v, req, c} = '0;
    {modulo_enable, modulo_ptr_select, modulo_start, modulo_end,
     bitrev_enable, bitrev_pointer_select, bitrev_modifier} = '0;
    repeat (6) @(posedge sys_clk);
    check(res_valid, 1'b0);
    arst_n <= 1'b1;
    // 16-word buffer on a 32-byte boundary, modifier half its size
    c = '{1'b1, 4'h3, 16'h0800, 16'h081F, 1'b1, 4'h3, 15'h0008};
    for (int i = 0; i < 17; i++)
    begin
      p = 16'h0800 + (flip(16'(i)) >> 11);
      r = '{4'h3, p, BRMAGU_MODE_POST_INC, 16'h0000, 1'b1, 1'b0, 1'b1};
      issue(r, 1'b1, c);
      if (i > 0)
        check(res.wb_val, 16'h0800 + (flip(16'(i % 16)) >> 11));
    end
    $display("mirror sequence test done");
    for (int k = 0; k < 400; k++)
    begin
      w = $random(seed);
      if (k % 25 == 0)
      begin
        c = '{w[0], {2'b00, w[2:1]}, 16'h2000,
              16'h2007 + {8'h00, w[7:3], 3'h0}, w[8],
              w[9] ? STACK_IDX : {2'b00, w[11:10]},
              15'(15'h0001 << (w[15:12] % 4'd10))};
        issue(r, 1'b0, c);
        w = $random(seed);
      end
      r = '{{2'b00, w[1:0]}, 16'h1FF0 + {10'h000, w[7:3], 1'b0},
            brmagu_mode_t'(w[10:8] % 3'd6), {{10{w[16]}}, w[16:11]},
            w[17], w[18], w[19]};
      issue(r, |w[22:20], c);
    end
    issue(r, 1'b0, c);
    issue(r, 1'b0, c);
    check(seen_count, 16'(n_req));
    $display("random mix test done");
    tally_and_finish();
  end
endmodule : brmagu_agu_test
